/* ppcp_pkg.sv */
// constants and types shared by the pse port control pin logic
package ppcp_pkg;
    localparam int NPORT = 8;
    localparam int PRIO_W = 3;
    localparam int PULSE_W = 4;
    localparam int TMR_W = 26;
    localparam int FILT_W = 8;
    localparam int CLK_NS = 10;
    // deglitch window, shortest allowed filter time
    localparam int FILTER_NS = 1000;
    localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    // discharge backoff before detection
    localparam int BACKOFF_MS = 400;
    localparam int BACKOFF_CYC = BACKOFF_MS * 1000000 / CLK_NS;
    // idle gap that closes a shutdown pulse train
    localparam int OSS_GAP_NS = 20000;
    localparam int OSS_GAP_CYC = (OSS_GAP_NS + CLK_NS - 1) / CLK_NS;
    // dwell per detection point and classification window
    localparam int DET_STEP_NS = 10000;
    localparam int DET_STEP_CYC = (DET_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLASS_NS = 20000;
    localparam int CLASS_CYC = (CLASS_NS + CLK_NS - 1) / CLK_NS;
    // internal power-on reset stretch
    localparam int POR_NS = 10000;
    localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] DET_LAST_POINT = 2'h3;
    localparam logic [PULSE_W-1:0] OSS_MAX_PULSES = 4'h8;
    localparam logic [2:0] I2C_ADDR_BASE = 3'h2;

    typedef enum logic [2:0] {
        PORT_OFF,
        PORT_BACKOFF,
        PORT_DETECT,
        PORT_CLASSIFY,
        PORT_ON
    } ppcp_port_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic q;
        logic [FILT_W-1:0] cnt;
    } ppcp_filt_st_t;
endpackage : ppcp_pkg

/* ppcp_deglitch.sv */
// two-flop synchroniser followed by a symmetric deglitch counter
`timescale 1ns/1ps
module ppcp_deglitch #(
    parameter int FILTER_CYCLES = ppcp_pkg::FILTER_CYC,
    parameter bit RESET_VAL = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // pin and filtered level
    input wire logic pinIn,
    output logic filtered
);
    localparam int FW = ppcp_pkg::FILT_W;

    ppcp_pkg::ppcp_filt_st_t st;
    ppcp_pkg::ppcp_filt_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        if (st.s2 == st.q) begin
            next_st.cnt = '0;
        end else if (st.cnt == FW'(FILTER_CYCLES - 1)) begin
            next_st.q = st.s2;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = FW'(st.cnt + 1'b1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '{s1: RESET_VAL, s2: RESET_VAL, q: RESET_VAL, cnt: '0};
        end else begin
            st <= next_st;
        end
    end

    assign filtered = st.q;

    filt_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st.q != $past(st.q)) |-> $past(st.cnt) == FW'(FILTER_CYCLES - 1))
        else $error("filtered level changed before the filter time");
endmodule : ppcp_deglitch

/* ppcp_port_ctrl.sv */
// pin level control of an eight port power sourcing controller
`timescale 1ns/1ps
module ppcp_port_ctrl #(
    parameter int BACKOFF_CYCLES = ppcp_pkg::BACKOFF_CYC,
    parameter int DET_STEP_CYCLES = ppcp_pkg::DET_STEP_CYC,
    parameter int CLASS_CYCLES = ppcp_pkg::CLASS_CYC,
    parameter int OSS_GAP_CYCLES = ppcp_pkg::OSS_GAP_CYC,
    parameter int POR_CYCLES = ppcp_pkg::POR_CYC,
    parameter int FILTER_CYCLES = ppcp_pkg::FILTER_CYC
) (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic resetn,
    // pins from the board
    input wire logic resetPinN,
    input wire logic fastPortShutdownIn,
    input wire logic supplyOk,
    input wire logic [ppcp_pkg::NPORT-1:0] manualShutdown,
    input wire logic [ppcp_pkg::NPORT-1:0] fastOverload,
    input wire logic [ppcp_pkg::NPORT-1:0] portVoltageHigh,
    input wire logic autoPinFloating,
    input wire logic [2:0] autoLevelCode,
    input wire logic [3:0] i2cAddressStraps,
    input wire logic i2cDataIn,
    // from the controller core
    input wire logic [7:0] intRegBits,
    input wire logic [ppcp_pkg::NPORT-1:0] portEnableReq,
    input wire logic [ppcp_pkg::NPORT-1:0] signatureValid,
    input wire logic [ppcp_pkg::NPORT-1:0] overcurrentTimeout,
    input wire logic shutdownMode3Bit,
    input wire logic [ppcp_pkg::NPORT-1:0] shutdownEnable,
    input wire logic [ppcp_pkg::NPORT*ppcp_pkg::PRIO_W-1:0] portPriority,
    input wire logic i2cDataOutLow,
    // open-drain pins and the synchronised data in
    output logic intPinOut,
    output logic intPinOe,
    output logic i2cDataOut,
    output logic i2cDataOutOe,
    output logic i2cDataInSync,
    // per port drive
    output logic [ppcp_pkg::NPORT-1:0] fetGateDrive,
    output logic [ppcp_pkg::NPORT-1:0] dischargeEn,
    output logic [ppcp_pkg::NPORT-1:0] monitorResistorEn,
    output logic [ppcp_pkg::NPORT-1:0] probeSink,
    output logic [ppcp_pkg::NPORT-1:0] probeHigh,
    output logic [ppcp_pkg::NPORT-1:0] detectSample,
    output logic [ppcp_pkg::NPORT-1:0] classifyActive,
    output logic [ppcp_pkg::NPORT-1:0] portResetPulse,
    // status toward the core
    output logic registersClear,
    output logic autonomousEn,
    output logic [2:0] powerAllocLevel,
    output logic [6:0] slaveAddr
);
    localparam int NP = ppcp_pkg::NPORT;
    localparam int TW = ppcp_pkg::TMR_W;
    localparam int PW = ppcp_pkg::PRIO_W;
    localparam int CW = ppcp_pkg::PULSE_W;

    typedef struct packed {
        logic [TW-1:0] porCnt;
        logic porDone;
        logic sysRst;
        logic sup1;
        logic sup2;
        logic [NP-1:0] man1;
        logic [NP-1:0] man2;
        logic [NP-1:0] ovl1;
        logic [NP-1:0] ovl2;
        logic [NP-1:0] vhi1;
        logic [NP-1:0] vhi2;
        logic autoF1;
        logic autoF2;
        logic [2:0] autoL1;
        logic [2:0] autoL2;
        logic [3:0] addr1;
        logic [3:0] addr2;
        logic sda1;
        logic ossPrev;
        logic [CW-1:0] pulseCnt;
        logic [TW-1:0] gapCnt;
        ppcp_pkg::ppcp_port_state_t [NP-1:0] pst;
        logic [NP-1:0][TW-1:0] tmr;
        logic [NP-1:0][1:0] step;
        logic intOe;
        logic sdaOe;
        logic sdaIn;
        logic [NP-1:0] gate;
        logic [NP-1:0] disch;
        logic [NP-1:0] monRes;
        logic [NP-1:0] sink;
        logic [NP-1:0] sinkHigh;
        logic [NP-1:0] sample;
        logic [NP-1:0] classify;
        logic [NP-1:0] portRst;
        logic regClr;
        logic autoEn;
        logic [2:0] allocLevel;
        logic [6:0] addr;
    } ppcp_ctrl_st_t;

    ppcp_ctrl_st_t st;
    ppcp_ctrl_st_t next_st;
    logic ossLevel;
    logic rstPinLevel;
    logic ossRise;
    logic rstNow;
    logic [CW-1:0] trainLevel;
    logic [NP-1:0] shutMask;
    logic [NP-1:0] kill;

    ppcp_deglitch #(.FILTER_CYCLES(FILTER_CYCLES), .RESET_VAL(1'b0)) u_oss_filter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(fastPortShutdownIn),
        .filtered(ossLevel)
    );

    ppcp_deglitch #(.FILTER_CYCLES(FILTER_CYCLES), .RESET_VAL(1'b1)) u_rst_filter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(resetPinN),
        .filtered(rstPinLevel)
    );

    always_comb begin
        next_st = st;
        // pin synchronisers
        next_st.sup1 = supplyOk;
        next_st.sup2 = st.sup1;
        next_st.man1 = manualShutdown;
        next_st.man2 = st.man1;
        next_st.ovl1 = fastOverload;
        next_st.ovl2 = st.ovl1;
        next_st.vhi1 = portVoltageHigh;
        next_st.vhi2 = st.vhi1;
        next_st.autoF1 = autoPinFloating;
        next_st.autoF2 = st.autoF1;
        next_st.autoL1 = autoLevelCode;
        next_st.autoL2 = st.autoL1;
        next_st.addr1 = i2cAddressStraps;
        next_st.addr2 = st.addr1;
        next_st.sda1 = i2cDataIn;
        next_st.sdaIn = st.sda1;
        next_st.sdaOe = i2cDataOutLow;
        next_st.intOe = |intRegBits;

        // power-on reset stretch runs regardless of the reset pin
        if (!st.porDone) begin
            if (st.porCnt == TW'(POR_CYCLES - 1)) begin
                next_st.porDone = 1'b1;
            end else begin
                next_st.porCnt = TW'(st.porCnt + 1'b1);
            end
        end
        rstNow = !st.porDone || !rstPinLevel;
        next_st.sysRst = rstNow;
        next_st.regClr = rstNow;

        // straps are followed during reset and frozen at release
        if (rstNow) begin
            next_st.autoEn = !st.autoF2;
            next_st.allocLevel = st.autoL2;
            next_st.addr = {ppcp_pkg::I2C_ADDR_BASE, st.addr2};
        end

        // fast shutdown decoding
        ossRise = ossLevel && !st.ossPrev;
        next_st.ossPrev = ossLevel;
        shutMask = '0;
        trainLevel = CW'(ppcp_pkg::OSS_MAX_PULSES - st.pulseCnt);
        if (rstNow) begin
            next_st.pulseCnt = '0;
            next_st.gapCnt = '0;
        end else if (shutdownMode3Bit) begin
            if (ossRise) begin
                next_st.gapCnt = '0;
                if (st.pulseCnt != ppcp_pkg::OSS_MAX_PULSES) begin
                    next_st.pulseCnt = CW'(st.pulseCnt + 1'b1);
                end
            end else if (st.pulseCnt != '0) begin
                if (ossLevel) begin
                    next_st.gapCnt = '0;
                end else if (st.gapCnt == TW'(OSS_GAP_CYCLES - 1)) begin
                    for (int p = 0; p < NP; p++) begin
                        shutMask[p] = {1'b0, portPriority[p*PW +: PW]} >= trainLevel;
                    end
                    next_st.pulseCnt = '0;
                    next_st.gapCnt = '0;
                end else begin
                    next_st.gapCnt = TW'(st.gapCnt + 1'b1);
                end
            end
        end else begin
            next_st.pulseCnt = '0;
            next_st.gapCnt = '0;
            if (ossRise) begin
                shutMask = shutdownEnable;
            end
        end

        // per port sequencers run independently, so classification overlaps
        for (int p = 0; p < NP; p++) begin
            kill[p] = rstNow || shutMask[p] || !st.sup2 || st.ovl2[p] || st.man2[p]
                || overcurrentTimeout[p] || !portEnableReq[p];
            next_st.sample[p] = 1'b0;
            next_st.portRst[p] = shutMask[p] && !rstNow;
            case (st.pst[p])
                ppcp_pkg::PORT_OFF: begin
                    if (st.vhi2[p]) begin
                        next_st.pst[p] = ppcp_pkg::PORT_BACKOFF;
                        next_st.tmr[p] = TW'(BACKOFF_CYCLES - 1);
                    end else begin
                        next_st.pst[p] = ppcp_pkg::PORT_DETECT;
                        next_st.tmr[p] = TW'(DET_STEP_CYCLES - 1);
                        next_st.step[p] = 2'h0;
                    end
                end
                ppcp_pkg::PORT_BACKOFF: begin
                    if (st.tmr[p] == '0) begin
                        next_st.pst[p] = ppcp_pkg::PORT_DETECT;
                        next_st.tmr[p] = TW'(DET_STEP_CYCLES - 1);
                        next_st.step[p] = 2'h0;
                    end else begin
                        next_st.tmr[p] = TW'(st.tmr[p] - 1'b1);
                    end
                end
                ppcp_pkg::PORT_DETECT: begin
                    if (st.tmr[p] == '0) begin
                        next_st.sample[p] = 1'b1;
                        if (st.step[p] == ppcp_pkg::DET_LAST_POINT) begin
                            if (signatureValid[p]) begin
                                next_st.pst[p] = ppcp_pkg::PORT_CLASSIFY;
                                next_st.tmr[p] = TW'(CLASS_CYCLES - 1);
                            end else begin
                                next_st.pst[p] = ppcp_pkg::PORT_OFF;
                            end
                        end else begin
                            next_st.step[p] = 2'(st.step[p] + 1'b1);
                            next_st.tmr[p] = TW'(DET_STEP_CYCLES - 1);
                        end
                    end else begin
                        next_st.tmr[p] = TW'(st.tmr[p] - 1'b1);
                    end
                end
                ppcp_pkg::PORT_CLASSIFY: begin
                    if (st.tmr[p] == '0) begin
                        next_st.pst[p] = ppcp_pkg::PORT_ON;
                    end else begin
                        next_st.tmr[p] = TW'(st.tmr[p] - 1'b1);
                    end
                end
                ppcp_pkg::PORT_ON: begin
                    next_st.pst[p] = ppcp_pkg::PORT_ON;
                end
                default: begin
                    next_st.pst[p] = ppcp_pkg::PORT_OFF;
                end
            endcase
            if (kill[p]) begin
                next_st.pst[p] = ppcp_pkg::PORT_OFF;
                next_st.tmr[p] = '0;
                next_st.step[p] = 2'h0;
                next_st.sample[p] = 1'b0;
            end
            // pin drive follows the next sequencer state
            next_st.gate[p] = next_st.pst[p] == ppcp_pkg::PORT_ON;
            next_st.disch[p] = next_st.pst[p] == ppcp_pkg::PORT_BACKOFF;
            next_st.sink[p] = next_st.pst[p] == ppcp_pkg::PORT_DETECT;
            next_st.sinkHigh[p] = next_st.sink[p] && next_st.step[p][0];
            next_st.classify[p] = next_st.pst[p] == ppcp_pkg::PORT_CLASSIFY;
            next_st.monRes[p] = !(next_st.sink[p] || next_st.gate[p]);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.sysRst <= 1'b1;
            st.regClr <= 1'b1;
            st.monRes <= '1;
            st.addr <= 7'h7F;
        end else begin
            st <= next_st;
        end
    end

    assign intPinOut = 1'b0;
    assign intPinOe = st.intOe;
    assign i2cDataOut = 1'b0;
    assign i2cDataOutOe = st.sdaOe;
    assign i2cDataInSync = st.sdaIn;
    assign fetGateDrive = st.gate;
    assign dischargeEn = st.disch;
    assign monitorResistorEn = st.monRes;
    assign probeSink = st.sink;
    assign probeHigh = st.sinkHigh;
    assign detectSample = st.sample;
    assign classifyActive = st.classify;
    assign portResetPulse = st.portRst;
    assign registersClear = st.regClr;
    assign autonomousEn = st.autoEn;
    assign powerAllocLevel = st.allocLevel;
    assign slaveAddr = st.addr;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    int_pin_a: assert property (intPinOe == $past(|intRegBits))
        else $error("interrupt pin does not follow the interrupt bits");
    oss_reset_a: assert property ((portResetPulse != 8'h00) |->
        (fetGateDrive & portResetPulse) == 8'h00 && (probeSink & portResetPulse) == 8'h00)
        else $error("port still driven after fast shutdown");
    pin_reset_a: assert property (!rstPinLevel |=> registersClear && fetGateDrive == 8'h00)
        else $error("reset pin did not clear ports and registers");
    por_hold_a: assert property (!st.porDone |=> registersClear)
        else $error("registers released before power-on reset finished");
    backoff_excl_a: assert property ((dischargeEn & (probeSink | fetGateDrive)) == 8'h00)
        else $error("discharge overlaps detection or power");
    probe_levels_a: assert property ($rose(probeSink[0]) |-> !probeHigh[0]
        && (probeHigh & ~probeSink) == 8'h00)
        else $error("probe level sequence broken");
    monitor_res_a: assert property ((monitorResistorEn ^ (probeSink | fetGateDrive)) == 8'hFF)
        else $error("monitor resistor state wrong");
    gate_supply_a: assert property (!st.sup2 |=> fetGateDrive == 8'h00)
        else $error("gate driven while supply low");
    gate_manual_a: assert property ((st.man2 != 8'h00) |=>
        (fetGateDrive & $past(st.man2)) == 8'h00)
        else $error("gate driven during manual shutdown");
    overload_off_a: assert property ($rose(|fastOverload) |->
        ##[1:4] (fetGateDrive & fastOverload) == 8'h00)
        else $error("fast overload did not remove gate drive in time");
    strap_addr_a: assert property (st.sysRst |=>
        slaveAddr == {ppcp_pkg::I2C_ADDR_BASE, $past(st.addr2)})
        else $error("slave address not formed from straps");
endmodule : ppcp_port_ctrl

/* ppcp_pd_model.sv */
// powered device and port capacitor model on the far side of each port
`timescale 1ns/1ps
module ppcp_pd_model (
    // clock
    input wire logic ref_clk,
    // drive from the controller
    input wire logic [7:0] dischargeEn,
    input wire logic [7:0] probeSink,
    input wire logic [7:0] fetGateDrive,
    // port side sense
    output logic [7:0] portVoltageHigh,
    output logic [7:0] signatureValid
);
    logic [7:0] charged = 8'h0F;
    logic [7:0] noise = 8'h5A;
    always @(posedge ref_clk) begin
        noise <= ~noise;
        // a powered port leaves its capacitor charged, only the bleed resistor empties it
        charged <= (charged | fetGateDrive) & ~dischargeEn;
    end
    assign portVoltageHigh = charged;
    // a valid device answers only while probed, otherwise the sense reads garbage
    assign signatureValid = probeSink | (~probeSink & noise);
endmodule : ppcp_pd_model

/* ppcp_port_ctrl_test.sv */
// self-checking bench for the port control pin logic
`timescale 1ns/1ps
module ppcp_port_ctrl_test;
    localparam int FC = 4;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic resetPinN = 1'b1;
    logic fastPortShutdownIn = 1'b0;
    logic supplyOk = 1'b1;
    logic [7:0] manualShutdown = 8'h00;
    logic [7:0] fastOverload = 8'h00;
    logic [7:0] overcurrentTimeout = 8'h00;
    logic [7:0] intRegBits = 8'h00;
    logic [7:0] portEnableReq = 8'h00;
    logic [7:0] shutdownEnable = 8'h00;
    logic shutdownMode3Bit = 1'b0;
    logic autoPinFloating = 1'b0;
    logic [2:0] autoLevelCode = 3'h5;
    logic [3:0] i2cAddressStraps = 4'hA;
    logic hostSda = 1'b1;
    logic i2cDataOutLow = 1'b0;
    // port p carries priority p
    logic [23:0] portPriority = 24'hFAC688;
    wire logic [7:0] portVoltageHigh;
    wire logic [7:0] signatureValid;
    wire logic i2cDataIn;
    logic intPinOut, intPinOe, i2cDataOut, i2cDataOutOe, i2cDataInSync;
    logic [7:0] fetGateDrive, dischargeEn, monitorResistorEn, probeSink, probeHigh;
    logic [7:0] detectSample, classifyActive, portResetPulse;
    logic registersClear, autonomousEn;
    logic [2:0] powerAllocLevel;
    logic [6:0] slaveAddr;
    int failures = 0;
    int cmpCount = 0;
    int cycles = 0;
    int seed = 99;
    logic [7:0] expQ[$];
    logic [7:0] sawDis = 8'h00;
    logic [7:0] detCnt = 8'h00;
    logic [7:0] disLen = 8'h00;
    logic [7:0] hiLen = 8'h00;
    logic multiClass = 1'b0;

    // host ties data in to the open-drain data out
    assign i2cDataIn = hostSda & ~i2cDataOutOe;
    always #5 ref_clk = ~ref_clk;

    ppcp_port_ctrl #(.BACKOFF_CYCLES(50), .DET_STEP_CYCLES(10), .CLASS_CYCLES(10),
        .OSS_GAP_CYCLES(20), .POR_CYCLES(8), .FILTER_CYCLES(FC)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .resetPinN(resetPinN),
        .fastPortShutdownIn(fastPortShutdownIn), .supplyOk(supplyOk),
        .manualShutdown(manualShutdown), .fastOverload(fastOverload),
        .portVoltageHigh(portVoltageHigh), .autoPinFloating(autoPinFloating),
        .autoLevelCode(autoLevelCode), .i2cAddressStraps(i2cAddressStraps),
        .i2cDataIn(i2cDataIn), .intRegBits(intRegBits), .portEnableReq(portEnableReq),
        .signatureValid(signatureValid), .overcurrentTimeout(overcurrentTimeout),
        .shutdownMode3Bit(shutdownMode3Bit), .shutdownEnable(shutdownEnable),
        .portPriority(portPriority), .i2cDataOutLow(i2cDataOutLow),
        .intPinOut(intPinOut), .intPinOe(intPinOe), .i2cDataOut(i2cDataOut),
        .i2cDataOutOe(i2cDataOutOe), .i2cDataInSync(i2cDataInSync),
        .fetGateDrive(fetGateDrive), .dischargeEn(dischargeEn),
        .monitorResistorEn(monitorResistorEn), .probeSink(probeSink),
        .probeHigh(probeHigh), .detectSample(detectSample),
        .classifyActive(classifyActive), .portResetPulse(portResetPulse),
        .registersClear(registersClear), .autonomousEn(autonomousEn),
        .powerAllocLevel(powerAllocLevel), .slaveAddr(slaveAddr)
    );

    ppcp_pd_model PD (
        .ref_clk(ref_clk), .dischargeEn(dischargeEn), .probeSink(probeSink),
        .fetGateDrive(fetGateDrive), .portVoltageHigh(portVoltageHigh),
        .signatureValid(signatureValid)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic wait_gates(input logic [7:0] exp);
        int n;
        n = 0;
        while (fetGateDrive !== exp && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        chk("gates", exp, fetGateDrive);
    endtask : wait_gates

    task automatic oss_pulse(input int hi, input int lo);
        fastPortShutdownIn = 1'b1;
        repeat (hi) @(negedge ref_clk);
        fastPortShutdownIn = 1'b0;
        repeat (lo) @(negedge ref_clk);
    endtask : oss_pulse

    // result watcher: every reset pulse must match the oldest expected mask
    always @(negedge ref_clk) begin
        if (|portResetPulse) begin
            if (expQ.size() == 0)
                chk("resetPulse", 8'h00, portResetPulse);
            else
                chk("resetPulse", expQ.pop_front(), portResetPulse);
        end
        sawDis <= sawDis | dischargeEn;
        detCnt <= detCnt + {7'h00, detectSample[4]};
        disLen <= disLen + {7'h00, dischargeEn[0]};
        hiLen <= hiLen + {7'h00, probeHigh[4]};
        if ($countones(classifyActive) > 1)
            multiClass <= 1'b1;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        logic [7:0] v;
        logic [7:0] snap [3];
        repeat (3) @(negedge ref_clk);
        chk("monitorRes", 8'hFF, monitorResistorEn);
        chk("regsClear", 8'h01, {7'h00, registersClear});
        chk("slaveAddr", 8'h7F, {1'b0, slaveAddr});
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (14) @(negedge ref_clk);
        chk("regsClear", 8'h00, {7'h00, registersClear});
        chk("slaveAddr", 8'h2A, {1'b0, slaveAddr});
        chk("autoEn", 8'h01, {7'h00, autonomousEn});
        chk("allocLevel", 8'h05, {5'h00, powerAllocLevel});
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            intRegBits = (i < 2) ? 8'h00 : v;
            i2cDataOutLow = v[0];
            hostSda = v[1];
            repeat (4) @(negedge ref_clk);
            chk("intOe", {7'h00, |intRegBits}, {7'h00, intPinOe});
            chk("intOut", 8'h00, {7'h00, intPinOut});
            chk("sdaOe", {7'h00, v[0]}, {7'h00, i2cDataOutOe});
            chk("sdaOut", 8'h00, {7'h00, i2cDataOut});
            chk("sdaIn", {7'h00, v[1] & ~v[0]}, {7'h00, i2cDataInSync});
        end
        i2cDataOutLow = 1'b0;
        $display("test interrupt and data lines done");
        portEnableReq = 8'hFF;
        wait_gates(8'hFF);
        snap[0] = detCnt;
        snap[1] = disLen;
        snap[2] = sawDis;
        chk("monitorRes", 8'h00, monitorResistorEn);
        chk("discharged", 8'h0F, snap[2]);
        chk("detPoints", 8'h04, snap[0]);
        chk("probeHighLen", 8'h14, hiLen);
        chk("backoffOk", 8'h01, {7'h00, snap[1] >= 8'd50 && snap[1] <= 8'd52});
        chk("classMulti", 8'h01, {7'h00, multiClass});
        $display("test power up done");
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: overcurrentTimeout = 8'h02;
                1: manualShutdown = 8'h04;
                2: fastOverload = 8'h08;
                default: supplyOk = 1'b0;
            endcase
            repeat (6) @(negedge ref_clk);
            v = (k == 3) ? 8'h00 : ~(8'h02 << k);
            chk("gateKill", v, fetGateDrive);
            overcurrentTimeout = 8'h00;
            manualShutdown = 8'h00;
            fastOverload = 8'h00;
            supplyOk = 1'b1;
            wait_gates(8'hFF);
        end
        $display("test gate kills done");
        shutdownEnable = 8'h3C;
        oss_pulse(FC - 2, 20);
        chk("gatesShort", 8'hFF, fetGateDrive);
        expQ.push_back(8'h3C);
        fastPortShutdownIn = 1'b1;
        repeat (FC + 10) @(negedge ref_clk);
        chk("gates1Bit", 8'hC3, fetGateDrive);
        fastPortShutdownIn = 1'b0;
        wait_gates(8'hFF);
        $display("test one bit shutdown done");
        shutdownMode3Bit = 1'b1;
        for (int n = 1; n <= 8; n++) begin
            expQ.push_back(~((8'h01 << (8 - n)) - 8'h01));
            for (int j = 0; j < n; j++)
                oss_pulse(FC + 4, FC + 4);
            repeat (40) @(negedge ref_clk);
            chk("trainDone", 8'h00, expQ.size());
            wait_gates(8'hFF);
        end
        $display("test three bit shutdown done");
        resetPinN = 1'b0;
        repeat (2) @(negedge ref_clk);
        resetPinN = 1'b1;
        repeat (12) @(negedge ref_clk);
        chk("gatesGlitch", 8'hFF, fetGateDrive);
        resetPinN = 1'b0;
        v = $random(seed);
        autoPinFloating = 1'b1;
        autoLevelCode = v[2:0];
        i2cAddressStraps = v[7:4];
        repeat (FC + 6) @(negedge ref_clk);
        chk("pinClear", 8'h01, {7'h00, registersClear});
        chk("pinGates", 8'h00, fetGateDrive);
        resetPinN = 1'b1;
        wait_gates(8'hFF);
        chk("slaveAddr", {1'b0, ppcp_pkg::I2C_ADDR_BASE, v[7:4]}, {1'b0, slaveAddr});
        chk("autoEn", 8'h00, {7'h00, autonomousEn});
        chk("allocLevel", {5'h00, v[2:0]}, {5'h00, powerAllocLevel});
        $display("test reset pin done");
        tally_and_finish();
    end
endmodule : ppcp_port_ctrl_test
